// ==== hdl/mor_pkg.sv ====
// Function
// RULE_01: Four-bit variant: pointer load copies accumulator bits 3:0 into pointer bits 3:0.
// RULE_02: Five-bit variant: pointer load copies accumulator bits 4:0 into pointer bits 4:0.
// RULE_03: Pointer load leaves accumulator and every status flag untouched.
// RULE_04: Pointer value selects the port control register for later port-control moves.
// RULE_05: Timer configuration write copies whole accumulator, accumulator and flags untouched.
// RULE_06: Timer configuration register contents set up the real time counter.
// RULE_07: Its fields drive counter interrupt enable, increment event select, prescaler assignment.
// RULE_08: Port-control move carries four-bit port field, values 5 to 9 mean ports A-E.
// RULE_09: Pointer load and timer configuration write each finish in one instruction cycle.
package mor_pkg;

	// ****************************************************************
	// Widths and opcodes
	// ****************************************************************
	localparam int         INSTR_W          = 12;
	localparam int         ACC_W            = 8;
	localparam int         PTR_W_MAX        = 5;
	localparam int         PTR_W_DEFAULT    = 4;
	localparam logic [11:0] OP_PTR_FROM_ACC = 12'h043;
	localparam logic [11:0] OP_TCFG_WRITE   = 12'h002;
	localparam logic [7:0]  OP_PORT_MOVE_HI = 8'h00;
	localparam logic [3:0]  PORT_FIELD_A    = 4'h5;
	localparam logic [3:0]  PORT_FIELD_E    = 4'h9;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [4:0] PTR_RESET        = 5'h00;
	localparam logic [7:0] TCFG_RESET       = 8'hFF;
	localparam logic [7:0] CTRL_RESET       = 8'h01;

	// ****************************************************************
	// Timer configuration field positions
	// ****************************************************************
	localparam int TCFG_IRQ_EN_BIT   = 6;
	localparam int TCFG_EVENT_BIT    = 5;
	localparam int TCFG_EDGE_BIT     = 4;
	localparam int TCFG_PSA_BIT      = 3;
	localparam int TCFG_PS_LSB       = 0;
	localparam int TCFG_PS_W         = 3;

	// ****************************************************************
	// Register port map
	// ****************************************************************
	localparam int         REG_ADDR_W       = 2;
	localparam logic [1:0] REG_PTR          = 2'h0;
	localparam logic [1:0] REG_TCFG         = 2'h1;
	localparam logic [1:0] REG_COUNT        = 2'h2;
	localparam logic [1:0] REG_CTRL         = 2'h3;
	localparam int         CTRL_EXEC_EN_BIT = 0;

	// Port-control move request towards the port block
	typedef struct packed {
		logic       valid;
		logic [2:0] port;
		logic [4:0] sel;
		logic [7:0] data;
	} mor_port_req_s;

	// Real time counter setup decoded from the timer configuration
	typedef struct packed {
		logic       irq_en;
		logic       event_ext;
		logic       edge_fall;
		logic       psa_wdt;
		logic [2:0] prescale;
	} mor_rtc_cfg_s;

endpackage

// ==== hdl/mor_top.sv ====
`timescale 1ns/1ps
module mor_top #(
	parameter int PTR_W = mor_pkg::PTR_W_DEFAULT
) (
	// Clock, reset, enable
	input  wire logic                          core_clk_in,
	input  wire logic                          rst_n_in,
	input  wire logic                          ce_in,
	// Instruction stream
	input  wire logic                          instr_valid_in,
	input  wire logic [mor_pkg::INSTR_W-1:0]   instr_in,
	input  wire logic [mor_pkg::ACC_W-1:0]     acc_in,
	// Register port
	input  wire logic [mor_pkg::REG_ADDR_W-1:0] reg_addr_in,
	input  wire logic [7:0]                    reg_wdata_in,
	input  wire logic                          reg_wr_in,
	input  wire logic                          reg_rd_in,
	output logic      [7:0]                    reg_rdata_out,
	// Core side results
	output logic                               done_out,
	output logic                               acc_we_out,
	output logic                               flags_we_out,
	output logic      [mor_pkg::PTR_W_MAX-1:0] ptr_out,
	output logic      [mor_pkg::ACC_W-1:0]     tcfg_out,
	output mor_pkg::mor_rtc_cfg_s              rtc_cfg_out,
	output mor_pkg::mor_port_req_s             port_req_out
);
	import mor_pkg::*;

	// ****************************************************************
	// Decode
	// ****************************************************************

	// Port field to port index, all-ones when the field names no port
	function automatic logic [2:0] port_index(input logic [11:0] op);
		logic [2:0] idx;
		idx = 3'h7;
		if (op[11:4] == OP_PORT_MOVE_HI && op[3:0] >= PORT_FIELD_A && op[3:0] <= PORT_FIELD_E) begin
			idx = 3'(op[3:0] - PORT_FIELD_A);
		end
		return idx;
	endfunction

	// Mask that keeps only the pointer bits this variant implements
	function automatic logic [4:0] ptr_mask(input logic [7:0] v);
		logic [4:0] m;
		m = '0;
		for (int i = 0; i < PTR_W_MAX; i++) begin
			m[i] = (i < PTR_W) ? v[i] : 1'b0;
		end
		return m;
	endfunction

	logic [7:0] ctrl;
	logic [7:0] exec_count;
	logic       exec_en;
	logic       go;
	logic       is_ptr_load;
	logic       is_tcfg_wr;
	logic [2:0] port_idx;
	logic       is_port_move;
	logic [4:0] next_ptr;
	logic [7:0] next_tcfg;

	// Software can hold the decoder off, e.g. while it rewrites config
	assign exec_en      = ctrl[CTRL_EXEC_EN_BIT];
	assign go           = ce_in && instr_valid_in && exec_en;
	assign is_ptr_load  = go && (instr_in == OP_PTR_FROM_ACC);
	assign is_tcfg_wr   = go && (instr_in == OP_TCFG_WRITE);
	assign port_idx     = port_index(instr_in);
	assign is_port_move = go && (port_idx != 3'h7);            // [RULE_08]

	// Upper pointer bits stay zero on the narrow variant
	assign next_ptr  = is_ptr_load ? ptr_mask(acc_in) : ptr_out; // [RULE_01] [RULE_02]
	assign next_tcfg = is_tcfg_wr ? acc_in : tcfg_out;          // [RULE_05]

	// ****************************************************************
	// Pointer register
	// ****************************************************************

	// Held until the next pointer load, so a run of port moves shares it
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ptr_out <= PTR_RESET;
		end else if (ce_in) begin
			ptr_out <= next_ptr;                                    // [RULE_04]
		end
	end

	// ****************************************************************
	// Timer configuration register
	// ****************************************************************

	// Whole word taken, no field is filtered
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tcfg_out <= TCFG_RESET;
		end else if (ce_in) begin
			tcfg_out <= next_tcfg;
		end
	end

	// Counter setup is taken from the register's next value, so it updates on the same edge
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rtc_cfg_out <= '0;
		end else if (ce_in) begin
			rtc_cfg_out.irq_en    <= ~next_tcfg[TCFG_IRQ_EN_BIT];   // [RULE_06] [RULE_07]
			rtc_cfg_out.event_ext <= next_tcfg[TCFG_EVENT_BIT];    // [RULE_07]
			rtc_cfg_out.edge_fall <= next_tcfg[TCFG_EDGE_BIT];
			rtc_cfg_out.psa_wdt   <= next_tcfg[TCFG_PSA_BIT];      // [RULE_07]
			rtc_cfg_out.prescale  <= next_tcfg[TCFG_PS_LSB +: TCFG_PS_W];
		end
	end

	// ****************************************************************
	// Port-control move request
	// ****************************************************************

	// Pointer sampled as it stands before this cycle's update
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			port_req_out <= '0;
		end else if (ce_in) begin
			port_req_out.valid <= is_port_move;
			port_req_out.port  <= is_port_move ? port_idx : 3'h0; // [RULE_08]
			port_req_out.sel   <= ptr_out;                        // [RULE_04]
			port_req_out.data  <= acc_in;
		end
	end

	// ****************************************************************
	// Completion and side effects
	// ****************************************************************

	// Single cycle, no wait state; none of these touch W or flags
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			done_out     <= 1'b0;
			acc_we_out   <= 1'b0;
			flags_we_out <= 1'b0;
		end else if (ce_in) begin
			done_out     <= is_ptr_load || is_tcfg_wr || is_port_move; // [RULE_09]
			acc_we_out   <= 1'b0;                                   // [RULE_03] [RULE_05]
			flags_we_out <= 1'b0;                                   // [RULE_03] [RULE_05]
		end
	end

	// Executed-instruction counter, wraps, cleared by a write
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			exec_count <= 8'h00;
		end else if (ce_in) begin
			if (reg_wr_in && reg_addr_in == REG_COUNT) begin
				exec_count <= 8'h00;
			end else if (is_ptr_load || is_tcfg_wr || is_port_move) begin
				exec_count <= exec_count + 8'h01;
			end
		end
	end

	// ****************************************************************
	// Register port
	// ****************************************************************

	// Control register, the only one that keeps write data (a counter write only clears it)
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl <= CTRL_RESET;
		end else if (ce_in && reg_wr_in && reg_addr_in == REG_CTRL) begin
			ctrl <= {7'h00, reg_wdata_in[CTRL_EXEC_EN_BIT]};
		end
	end

	// Read data valid in the cycle after the strobe, zero otherwise
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= 8'h00;
		end else if (ce_in) begin
			if (reg_rd_in) begin
				case (reg_addr_in)
					REG_PTR:   reg_rdata_out <= {3'h0, ptr_out};
					REG_TCFG:  reg_rdata_out <= tcfg_out;
					REG_COUNT: reg_rdata_out <= exec_count;
					REG_CTRL:  reg_rdata_out <= ctrl;
					default:   reg_rdata_out <= 8'h00;
				endcase
			end else begin
				reg_rdata_out <= 8'h00;
			end
		end
	end

endmodule

// ==== dv/mor_assertions.sv ====
`timescale 1ns/1ps
module mor_assertions import mor_pkg::*; #(
	parameter int PTR_W = PTR_W_DEFAULT
) (
	// Clock, reset and inputs
	input wire logic                  core_clk_in,
	input wire logic                  rst_n_in,
	input wire logic                  ce_in,
	input wire logic                  instr_valid_in,
	input wire logic [INSTR_W-1:0]    instr_in,
	input wire logic [ACC_W-1:0]      acc_in,
	input wire logic [REG_ADDR_W-1:0] reg_addr_in,
	input wire logic [7:0]            reg_wdata_in,
	input wire logic                  reg_wr_in,
	input wire logic                  reg_rd_in,
	// Outputs
	input wire logic [7:0]            reg_rdata_out,
	input wire logic                  done_out,
	input wire logic                  acc_we_out,
	input wire logic                  flags_we_out,
	input wire logic [PTR_W_MAX-1:0]  ptr_out,
	input wire logic [ACC_W-1:0]      tcfg_out,
	input wire mor_rtc_cfg_s          rtc_cfg_out,
	input wire mor_port_req_s         port_req_out
);
	logic en;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Shadow of the decoder enable, since it is not visible at the ports
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) en <= 1'b1;
		else if (ce_in && reg_wr_in && reg_addr_in == REG_CTRL) en <= reg_wdata_in[0];
	end
	sequence s_take; ce_in && instr_valid_in && en; endsequence
	sequence s_ld; s_take ##0 instr_in == OP_PTR_FROM_ACC; endsequence
	sequence s_tc; s_take ##0 instr_in == OP_TCFG_WRITE; endsequence
	sequence s_pm; s_take ##0 instr_in >= 12'h005 && instr_in <= 12'h009; endsequence
	ptr_load_a: assert property (s_ld |=> done_out && ptr_out == 5'($past(acc_in) & ((1 << PTR_W) - 1)))
		else $error("pointer load wrong");
	ptr_upper_a: assert property ((ptr_out >> PTR_W) == 0) else $error("pointer upper bits set");
	no_side_a: assert property (!acc_we_out && !flags_we_out) else $error("acc or flags written");
	tcfg_load_a: assert property (s_tc |=> done_out && tcfg_out == $past(acc_in))
		else $error("timer config load wrong");
	rtc_map_a: assert property ($past(rst_n_in) |-> rtc_cfg_out == {~tcfg_out[6], tcfg_out[5:0]})
		else $error("counter setup mismatch");
	port_move_a: assert property (s_pm |=> port_req_out.valid && port_req_out.data == $past(acc_in) &&
		port_req_out.sel == $past(ptr_out) && port_req_out.port == 3'($past(instr_in) - 12'h005))
		else $error("port move wrong");
	done_cause_a: assert property (done_out |-> $past(instr_valid_in && ce_in && en))
		else $error("done without request");
	rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
		else $error("read data outside slot");
endmodule
bind mor_top mor_assertions #(.PTR_W(PTR_W)) u_chk (.*);

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
	$display("[FAIL] %0t %h %h", $time, (a), (b)); end end
module testbench;
	import mor_pkg::*;
	logic core_clk_in = 0, rst_n_in = 0, ce_in = 1, instr_valid_in = 0, reg_wr_in = 0, reg_rd_in = 0;
	logic [11:0] instr_in = 0;
	logic [7:0] acc_in = 0, reg_wdata_in = 0, reg_rdata_out, tcfg_out;
	logic [1:0] reg_addr_in = 0;
	logic done_out, acc_we_out, flags_we_out;
	logic [4:0] ptr_out, ptr5;
	mor_rtc_cfg_s rtc_cfg_out;
	mor_port_req_s port_req_out;
	int error_cnt = 0, samples_checked = 0, cyc = 0;
	mor_top #(.PTR_W(4)) DUT (.*);
	// Wide pointer variant shares the stimulus, only its pointer is compared
	mor_top #(.PTR_W(5)) DUT_W5 (
		.core_clk_in    (core_clk_in),
		.rst_n_in       (rst_n_in),
		.ce_in          (ce_in),
		.instr_valid_in (instr_valid_in),
		.instr_in       (instr_in),
		.acc_in         (acc_in),
		.reg_addr_in    (reg_addr_in),
		.reg_wdata_in   (reg_wdata_in),
		.reg_wr_in      (reg_wr_in),
		.reg_rd_in      (reg_rd_in),
		.reg_rdata_out  (),
		.done_out       (),
		.acc_we_out     (),
		.flags_we_out   (),
		.ptr_out        (ptr5),
		.tcfg_out       (),
		.rtc_cfg_out    (),
		.port_req_out   ()
	);
	// ****************************************************************
	// Clock, timeout and bus tasks
	// ****************************************************************
	initial forever #2.5 core_clk_in = ~core_clk_in;
	// Ceiling well above the roughly 70 cycles the tests need
	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge core_clk_in) begin reg_addr_in <= a; reg_wdata_in <= d; reg_wr_in <= 1; end
		@(posedge core_clk_in) reg_wr_in <= 0;
	endtask
	// Read data is only valid in the slot right after the strobe
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		@(posedge core_clk_in) begin reg_addr_in <= a; reg_rd_in <= 1; end
		@(posedge core_clk_in) reg_rd_in <= 0;
		#1 `CHK(reg_rdata_out, e)
	endtask
	task automatic ex(input logic [11:0] op, input logic [7:0] w, input logic d);
		@(posedge core_clk_in) begin instr_in <= op; acc_in <= w; instr_valid_in <= 1; end
		@(posedge core_clk_in) instr_valid_in <= 0;
		#1 `CHK(done_out, d)
	endtask
	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		repeat (20) @(posedge core_clk_in);
		rst_n_in <= 1;
		rd(REG_TCFG, TCFG_RESET);
		rd(REG_CTRL, CTRL_RESET);
		ex(OP_PTR_FROM_ACC, 8'h1D, 1);
		`CHK(ptr_out, 5'h0D)
		`CHK(ptr5, 5'h1D)
		`CHK(acc_we_out | flags_we_out, 1'b0)
		ex(OP_TCFG_WRITE, 8'h3F, 1);
		`CHK(tcfg_out, 8'h3F)
		`CHK(rtc_cfg_out, 7'h7F)
		rd(REG_TCFG, 8'h3F);
		for (int p = 5; p <= 9; p++) begin
			ex(12'(p), 8'(8'hA0 + p), 1);
			`CHK(port_req_out, {1'b1, 3'(p - 5), 5'h0D, 8'(8'hA0 + p)})
		end
		ex(12'h00A, 8'h11, 0);
		ex(12'h004, 8'h11, 0);
		@(posedge core_clk_in) ce_in <= 0;
		ex(OP_TCFG_WRITE, 8'h00, 0);
		`CHK(tcfg_out, 8'h3F)
		@(posedge core_clk_in) ce_in <= 1;
		rd(REG_COUNT, 8'h07);
		wr(REG_COUNT, 8'h5A);
		rd(REG_COUNT, 8'h00);
		wr(REG_CTRL, 8'h00);
		ex(OP_PTR_FROM_ACC, 8'h1F, 0);
		rd(REG_CTRL, 8'h00);
		wr(REG_CTRL, 8'h01);
		wr(REG_PTR, 8'h1F);
		rd(REG_PTR, 8'h0D);
		ex(OP_PTR_FROM_ACC, 8'hF7, 1);
		`CHK(ptr5, 5'h17)
		ex(12'h007, 8'h3C, 1);
		`CHK(port_req_out, {1'b1, 3'h2, 5'h07, 8'h3C})
		report_and_stop();
	end
endmodule
